// ### common/srp_regs.vh
// constants for the spi register read port
`ifndef SRP_REGS_VH
`define SRP_REGS_VH
`define SRP_RW_BIT      3'd7
`define SRP_ADDR_MSB    3'd6
`define SRP_BYTE_BITS   4'd8
`define SRP_LAST_BIT    3'd7
`define SRP_RD_FLAG     1'b1
`define SRP_SDO_RST     1'b0
`define SRP_ADDR_RST    8'h00
`endif

// ### verilog/srp_sync.v
// two-stage synchroniser with edge detection on the second stage output
`timescale 1ns/1ps
module srp_sync #(
  parameter W = 3
) (
  input  wire         clk_sys,  // system clock
  input  wire         rst_n,    // sync reset, active low
  input  wire [W-1:0] din,      // asynchronous inputs
  output wire [W-1:0] dout,     // synchronised level
  output wire [W-1:0] rise,     // one-cycle rising pulse
  output wire [W-1:0] fall      // one-cycle falling pulse
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= {W{1'b1}};
      s2_q <= {W{1'b1}};
      s3_q <= {W{1'b1}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign dout = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule // srp_sync

// ### verilog/srp_read_port.v
// slave spi register read port: control byte, then auto-increment read data
`timescale 1ns/1ps
`include "srp_regs.vh"
module srp_read_port (
  input  wire       clk_sys,            // system clock, 125 MHz
  input  wire       rst_n,              // sync reset, active low
  input  wire       three_wire_enable,  // 1 selects three-wire mode
  input  wire       csb_n,              // select pin, active low
  input  wire       sck,                // serial clock pin
  input  wire       sdi_i,              // data pin input level
  output reg        sdi_o,              // data pin drive value (three-wire)
  output reg        sdi_oe,             // data pin drive enable
  output reg        sdo_o,              // serial output drive value
  output reg        sdo_oe,             // serial output drive enable
  output reg  [7:0] reg_addr,           // register address being read
  output reg        reg_rd,             // one-cycle fetch of reg_addr
  input  wire [7:0] reg_data,           // register data, valid cycle after reg_rd
  output reg        rd_mode11           // chosen mode: 1 = mode 11, 0 = mode 00
);
  // ****************************************
  // states
  // ****************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_CTRL = 2'b01;
  localparam ST_DATA = 2'b10;
  localparam ST_SKIP = 2'b11;

  wire [2:0] lvl;
  wire [2:0] rise;
  wire [2:0] fall;

  // ****************************************
  // pin synchronisers
  // ****************************************
  srp_sync #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({csb_n, sck, sdi_i}),
    .dout    (lvl),
    .rise    (rise),
    .fall    (fall)
  );

  wire cs_lvl  = lvl[2];
  wire cs_fall = fall[2];
  wire cs_rise = rise[2];
  wire sck_lvl = lvl[1];
  wire sck_r   = rise[1];
  wire sck_f   = fall[1];
  wire din_lvl = lvl[0];

  reg  [1:0] st_q;
  reg  [2:0] cnt_q;
  reg  [7:0] sh_q;
  reg        load_q;
  reg        three_q;
  reg        out_q;
  reg        first_f_q;
  // set at the first data fall, once the master has let go of the pin
  reg        drive_q;
  reg        sdo_oe_d;
  reg        sdi_oe_d;

  function [7:0] next_addr;
    input [7:0] a;
    begin
      next_addr = a + 8'h01;
    end
  endfunction

  // true on the eighth bit of a byte
  function last_bit;
    input [2:0] c;
    begin
      last_bit = (c == `SRP_LAST_BIT);
    end
  endfunction

  // shift one bit in at the lsb end
  function [7:0] shift_in;
    input [7:0] v;
    input       b;
    begin
      shift_in = {v[6:0], b};
    end
  endfunction

  // ****************************************
  // control and data sequencing
  // ****************************************
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q      <= ST_IDLE;
      cnt_q     <= 3'd0;
      sh_q      <= `SRP_ADDR_RST;
      reg_addr  <= `SRP_ADDR_RST;
      reg_rd    <= 1'b0;
      load_q    <= 1'b0;
      three_q   <= 1'b0;
      rd_mode11 <= 1'b0;
      first_f_q <= 1'b0;
      drive_q   <= 1'b0;
      out_q     <= `SRP_SDO_RST;
    end else begin
      reg_rd <= 1'b0;
      load_q <= reg_rd;
      if (cs_rise || cs_lvl) begin
        st_q    <= ST_IDLE;
        cnt_q   <= 3'd0;
        drive_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (cs_fall) begin
            rd_mode11 <= sck_lvl;
            three_q   <= three_wire_enable;
            cnt_q     <= 3'd0;
            st_q      <= ST_CTRL;
          end
        end
        ST_CTRL: begin
          if (sck_r && !cs_lvl) begin
            sh_q  <= shift_in(sh_q, din_lvl);
            cnt_q <= cnt_q + 3'd1;
            if (last_bit(cnt_q)) begin
              if (sh_q[6] == `SRP_RD_FLAG) begin
                reg_addr  <= {1'b1, sh_q[5:0], din_lvl};
                reg_rd    <= 1'b1;
                first_f_q <= 1'b1;
                st_q      <= ST_DATA;
              end else begin
                st_q <= ST_SKIP;
              end
            end
          end
        end
        ST_DATA: begin
          if (load_q) begin
            sh_q <= reg_data;
          end
          if (sck_f && !cs_lvl) begin
            drive_q <= 1'b1;
            if (first_f_q) begin
              first_f_q <= 1'b0;
              out_q     <= sh_q[7];
            end else begin
              out_q <= sh_q[6];
              sh_q  <= shift_in(sh_q, 1'b0);
            end
          end
          if (sck_r && !cs_lvl) begin
            cnt_q <= cnt_q + 3'd1;
            if (last_bit(cnt_q)) begin
              reg_addr  <= next_addr(reg_addr);
              reg_rd    <= 1'b1;
              first_f_q <= 1'b1;
            end
          end
        end
        ST_SKIP: begin
          if (cs_lvl) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // drive enables
  // ****************************************
  always @* begin
    sdo_oe_d = 1'b0;
    sdi_oe_d = 1'b0;
    if ((st_q == ST_DATA) && drive_q && !cs_lvl) begin
      if (three_q) begin
        sdi_oe_d = 1'b1;
      end else begin
        sdo_oe_d = 1'b1;
      end
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sdo_o  <= `SRP_SDO_RST;
      sdo_oe <= 1'b0;
      sdi_o  <= `SRP_SDO_RST;
      sdi_oe <= 1'b0;
    end else begin
      sdo_o  <= out_q;
      sdi_o  <= out_q;
      sdo_oe <= sdo_oe_d;
      sdi_oe <= sdi_oe_d;
    end
  end
endmodule // srp_read_port

// ### verification/srp_read_port_checker.sv
// assertions on the read port pins
`timescale 1ns/1ps
module srp_read_port_checker (
  input wire logic       clk_sys,            // system clock
  input wire logic       rst_n,              // sync reset, active low
  input wire logic       three_wire_enable,  // wire mode select
  input wire logic       csb_n,              // select pin, active low
  input wire logic       sck,                // serial clock pin
  input wire logic       sdi_i,              // data pin level
  input wire logic       sdi_o,              // data pin value
  input wire logic       sdi_oe,             // data pin enable
  input wire logic       sdo_o,              // serial out value
  input wire logic       sdo_oe,             // serial out enable
  input wire logic       reg_rd,             // fetch strobe
  input wire logic       rd_mode11,          // chosen clock mode
  input wire logic [7:0] reg_addr,           // fetch address
  input wire logic [7:0] reg_data            // fetched data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_idle_quiet: assert property (csb_n [*6] |-> !sdo_oe && !sdi_oe)
    else $error("pin driven while deselected");
  chk_pin_exclusive: assert property (!(sdo_oe && sdi_oe))
    else $error("both data pins driven");
  chk_three_wire_pin: assert property (sdi_oe |-> three_wire_enable)
    else $error("data pin driven in four-wire mode");
  chk_four_wire_pin: assert property (sdo_oe |-> !three_wire_enable)
    else $error("serial output driven in three-wire mode");
  chk_fetch_pulse: assert property (reg_rd |=> !reg_rd)
    else $error("fetch longer than one cycle");
  chk_fetch_read: assert property (reg_rd |-> !$past(csb_n, 8) && reg_addr[7])
    else $error("fetch outside a selected read");
  chk_mode_pick: assert property ($fell(csb_n) |-> ##6 rd_mode11 == $past(sck, 6))
    else $error("wrong clock mode picked");
  chk_oe_stands: assert property ((sdo_oe || sdi_oe) && !csb_n |=> sdo_oe || sdi_oe || csb_n)
    else $error("drive dropped while selected");
endmodule // srp_read_port_checker
bind srp_read_port srp_read_port_checker srp_read_port_checker_i (
  .clk_sys           (clk_sys),
  .rst_n             (rst_n),
  .three_wire_enable (three_wire_enable),
  .csb_n             (csb_n),
  .sck               (sck),
  .sdi_i             (sdi_i),
  .sdi_o             (sdi_o),
  .sdi_oe            (sdi_oe),
  .sdo_o             (sdo_o),
  .sdo_oe            (sdo_oe),
  .reg_rd            (reg_rd),
  .rd_mode11         (rd_mode11),
  .reg_addr          (reg_addr),
  .reg_data          (reg_data)
);

// ### verification/srp_spi_master.sv
// behavioural spi master facing the read port
`timescale 1ns/1ps
module srp_spi_master (
  output logic sck = 1'b0,     // serial clock
  output logic csb_n = 1'b1,   // select, active low
  output logic mosi = 1'b0,    // data to device
  output logic mosi_oe = 1'b1, // master drives data pin
  input  wire  miso            // data from device
);
  logic pol = 1'b0;
  task automatic open_x(input logic p);
    pol = p;
    sck = p;
    #40 csb_n = 1'b0;
    #32;
  endtask
  // read data taken at the rising edge
  task automatic byte_x(input logic [7:0] d, input logic rel, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      mosi = d[i];
      mosi_oe = !rel;
      #32 q[i] = miso;
      sck = 1'b1;
      #32;
    end
  endtask
  task automatic close_x();
    #32 sck = pol;
    #32 csb_n = 1'b1;
    mosi_oe = 1'b1;
    #64;
  endtask
endmodule // srp_spi_master

// ### verification/srp_read_port_tb.sv
// self-checking bench for the spi register read port
`timescale 1ns/1ps
module srp_read_port_tb;
  logic       clk_sys = 0, rst_n = 0, three_wire_enable = 0, seen_oe = 0, seen_rd = 0;
  logic [7:0] reg_data = 8'h00, q;
  wire        sck, csb_n, mosi, mosi_oe, sdi_o, sdi_oe, sdo_o, sdo_oe, reg_rd, rd_mode11;
  wire  [7:0] reg_addr;
  int         err_count = 0, check_count = 0, cyc = 0;
  // undriven lines show the inverse of the last value
  wire        sdi_i = sdi_oe ? sdi_o : (mosi_oe ? mosi : ~sdi_o);
  wire        miso = three_wire_enable ? sdi_i : (sdo_oe ? sdo_o : ~sdo_o);
  srp_read_port srp_read_port_i (.clk_sys(clk_sys), .rst_n(rst_n), .csb_n(csb_n),
    .three_wire_enable(three_wire_enable), .sck(sck), .sdi_i(sdi_i), .sdi_o(sdi_o),
    .sdi_oe(sdi_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_data(reg_data), .rd_mode11(rd_mode11));
  srp_spi_master srp_spi_master_i (.sck(sck), .csb_n(csb_n), .mosi(mosi),
    .mosi_oe(mosi_oe), .miso(miso));
  always #4 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    if (reg_rd) reg_data <= reg_addr ^ 8'h5A;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic t_read(input logic p, tw, input logic [7:0] ctl, input int n);
    @(negedge clk_sys);
    three_wire_enable = tw;
    seen_oe = 1'b0;
    srp_spi_master_i.open_x(p);
    srp_spi_master_i.byte_x(ctl, 1'b0, q);
    for (int k = 0; k < n; k++) begin
      srp_spi_master_i.byte_x(8'h00, tw, q);
      chk(q, ({1'b1, ctl[6:0]} + k[7:0]) ^ 8'h5A);
    end
    chk({7'h00, rd_mode11}, {7'h00, p});
    chk({7'h00, seen_oe}, 8'h01);
    srp_spi_master_i.close_x();
    $display("read test done");
  endtask
  task automatic t_write();
    @(negedge clk_sys);
    three_wire_enable = 1'b0;
    seen_oe = 1'b0;
    seen_rd = 1'b0;
    srp_spi_master_i.open_x(1'b0);
    srp_spi_master_i.byte_x(8'h76, 1'b0, q);
    srp_spi_master_i.byte_x(8'h3C, 1'b0, q);
    srp_spi_master_i.close_x();
    chk({6'h00, seen_oe, seen_rd}, 8'h00);
    $display("write test done");
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_read(1'b0, 1'b0, 8'hF6, 2);
    t_read(1'b1, 1'b0, 8'hF6, 3);
    t_write();
    t_read(1'b0, 1'b1, 8'h88, 2);
    t_read(1'b1, 1'b1, 8'hC0, 1);
    tally_and_finish();
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (three_wire_enable ? sdi_oe : sdo_oe) seen_oe <= 1'b1;
    if (reg_rd) seen_rd <= 1'b1;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end
endmodule // srp_read_port_tb
